// ==== verilog/dfr_cfg.svh ====
// Constants for the serial fault-reporting target: bit positions, addresses and counts
`ifndef DFR_CFG_SVH
`define DFR_CFG_SVH

// Global status byte bit positions
`define DFR_GS_FERR 7
`define DFR_GS_LOAD 6
`define DFR_GS_UV 5
`define DFR_GS_OV 4
`define DFR_GS_NOT_POWER_ON_RESET_FLAG 3
`define DFR_GS_TSD 2
`define DFR_GS_TPW 1
// Global status reset value: not-power-on-reset bit low, everything else clear
`define DFR_GS_RESET 8'h00
// Value after a read-and-clear: only the not-power-on-reset bit stays high
`define DFR_GS_CLEARED 8'h08

// Address byte fields
`define DFR_A_KIND 7
`define DFR_A_HI 6
`define DFR_A_LO 2
`define DFR_A_LAST_ADDRESS_TOKEN 1
`define DFR_A_LSB 0

// Register addresses, field A[6:2]
`define DFR_ADDR_GSTAT 5'h06
`define DFR_ADDR_RO 5'h19
`define DFR_CTRL_NUM 12
`define DFR_CTRL_ADDRS {5'h1a, 5'h0a, 5'h12, 5'h02, 5'h1c, 5'h0c, 5'h14, 5'h04, 5'h18, 5'h08, 5'h10, 5'h00}
`define DFR_STAT_NUM 7
`define DFR_STAT_ADDRS {5'h09, 5'h11, 5'h01, 5'h1e, 5'h0e, 5'h16, 5'h06}

// Frame length figures, in serial clock pulses
`define DFR_BYTE_BITS 12'd8
`define DFR_MIN_BITS 12'd16

`endif

// ==== verilog/dfr_pkg.sv ====
// Types shared by the serial fault-reporting target
package dfr_pkg;

  typedef struct packed {
    logic open_load_fault;
    logic overcurrent_fault;
    logic supply_undervoltage_flag;
    logic supply_overvoltage_flag;
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
  } dfr_fault_s;

  typedef enum logic [1:0] {
    DFR_K_UNUSED = 2'h0,
    DFR_K_CTRL = 2'h1,
    DFR_K_RO = 2'h3,
    DFR_K_STAT = 2'h2
  } dfr_kind_e;

endpackage

// ==== verilog/dfr_spi_target.sv ====
// Serial target: fault flag, global status byte, frame checks and in-frame response
`timescale 1ns/10ps
`include "dfr_cfg.svh"

// Notes on behaviour
// (R1) Before first rise, output is fault flag OR input
// (R2) Fault flag set by any fault or reset
// (R3) Controller holds first input low before first rise
// (R4) Select without clocks shows the fault flag
// (R5) Status byte leaves during the first eight clocks
// (R6) Status byte holds seven fault and reset flags
// (R7) Fault flag is OR of status, reset bit inverted
// (R8) Reset bit defaults low, fault flag high
// (R9) Frame error is bit 7, seen next frame
// (R10) Clock count must be zero or 8n, n>=2
// (R11) Unused register address is a frame error
// (R12) Address byte LSB low is a frame error
// (R13) Last address token low is a frame error
// (R14) Clock high at select edges is an error
// (R15) Controller sends address byte then data byte
// (R16) Data byte phase returns addressed register contents
// (R17) Chain: all addresses first, then all data
// (R18) Chain: token set only in last address
// (R19) Chain: flags first, then status bytes reversed
// (R20) Chain: responses follow status, in reverse order
// (R21) Controller verifies all registers after chain error
// (R22) Bit 7 picks read or write/clear
// (R23) Capture on falling edge, drive on rising
// (R24) Select high interprets frame, releases output
// (R25) Writes and clears apply only on clean frames
module dfr_spi_target
  import dfr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic spi_clk_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in,
  input wire dfr_fault_s faults_in,
  output logic serial_out,
  output logic serial_oe_out,
  output logic [7:0] status_out,
  output logic [`DFR_CTRL_NUM*8-1:0] ctrl_regs_out
);

  function automatic dfr_kind_e addr_kind(input logic [4:0] a);
    logic [`DFR_CTRL_NUM*5-1:0] ctl;
    logic [`DFR_STAT_NUM*5-1:0] sts;
    dfr_kind_e k;
    ctl = `DFR_CTRL_ADDRS;
    sts = `DFR_STAT_ADDRS;
    k = DFR_K_UNUSED;
    for (int i = 0; i < `DFR_CTRL_NUM; i++) begin
      if (ctl[i*5 +: 5] == a) begin
        k = DFR_K_CTRL;
      end
    end
    for (int i = 0; i < `DFR_STAT_NUM; i++) begin
      if (sts[i*5 +: 5] == a) begin
        k = DFR_K_STAT;
      end
    end
    if (a == `DFR_ADDR_RO) begin
      k = DFR_K_RO;
    end
    return k;
  endfunction

  function automatic logic [3:0] ctrl_idx(input logic [4:0] a);
    logic [`DFR_CTRL_NUM*5-1:0] ctl;
    logic [3:0] n;
    ctl = `DFR_CTRL_ADDRS;
    n = 4'h0;
    for (int i = 0; i < `DFR_CTRL_NUM; i++) begin
      if (ctl[i*5 +: 5] == a) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  // Reference domain state
  logic link_clr;
  logic cs_s1, cs_s2, cs_prev;
  logic sck_s1, sck_s2;
  logic tgl_s1, tgl_s2, tgl_seen;
  dfr_fault_s flt_s1, flt_s2;
  logic pol_seen;
  logic [7:0] gstat;
  logic [7:0] next_gstat;
  logic [7:0] snap;
  logic [7:0] ctrl_mem [`DFR_CTRL_NUM];

  // Link domain state
  logic rose, started;
  logic [11:0] nbits;
  logic [11:0] next_nbits;
  logic [7:0] rx_sr;
  logic [7:0] next_rx;
  logic [7:0] own_addr, data_byte;
  logic addr_done, lsb_err, frm_tgl;
  logic [11:0] resp_base;
  logic [11:0] pos_k;
  logic sdo_q, next_sdo;
  logic [7:0] resp;

  logic global_fault_flag, cs_fall, cs_rise, clocked, cnt_bad, addr_bad, frame_bad;
  logic apply, wr_en, clr_en;
  dfr_kind_e akind;

  // Fault flag: any set status bit, or the reset bit still low
  assign global_fault_flag = (|(gstat & ~(8'h01 << `DFR_GS_NOT_POWER_ON_RESET_FLAG))) | ~gstat[`DFR_GS_NOT_POWER_ON_RESET_FLAG]; // (R7)

  // The pre-clock window is a pure pass-through so a chain ORs without delay
  assign serial_out = rose ? sdo_q : (global_fault_flag | serial_in); // (R1) (R4)
  assign serial_oe_out = ~chip_select_n_in; // (R24)
  assign status_out = gstat;

  for (genvar g = 0; g < `DFR_CTRL_NUM; g++) begin : g_ctrl
    assign ctrl_regs_out[g*8 +: 8] = ctrl_mem[g];
  end

  // ---------------- Link domain ----------------
  always_ff @(posedge spi_clk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      rose <= 1'b0;
    end else begin
      rose <= 1'b1;
    end
  end

  always_ff @(negedge spi_clk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  // Frame marker toggles once per clocked frame; idle clock cannot be relied on for a reset
  always_ff @(negedge spi_clk_in or posedge link_clr) begin
    if (link_clr) begin
      frm_tgl <= 1'b0;
    end else if (!started && !chip_select_n_in) begin
      // Clock edges while deselected must not count as a frame
      frm_tgl <= ~frm_tgl;
    end
  end

  always_comb begin
    next_nbits = started ? nbits + 12'h001 : 12'h001;
    next_rx = {rx_sr[6:0], serial_in};
  end

  // Capture on the falling edge; results stay put after select rises for the other domain
  // Edges while deselected are ignored so the pending frame verdict is not disturbed
  always_ff @(negedge spi_clk_in) begin
    if (!chip_select_n_in) begin
      nbits <= next_nbits; // (R23)
      rx_sr <= next_rx;
      if (!started) begin
        addr_done <= 1'b0;
        lsb_err <= 1'b0;
      end
      if (next_nbits[2:0] == 3'h0) begin
        data_byte <= next_rx;
        if (!addr_done) begin
          if (!next_rx[`DFR_A_LSB]) begin
            lsb_err <= 1'b1; // (R12)
          end
          if (next_nbits == `DFR_BYTE_BITS) begin
            own_addr <= next_rx; // (R15) (R17)
          end
          if (next_rx[`DFR_A_LAST_ADDRESS_TOKEN]) begin
            addr_done <= 1'b1; // (R13) (R18)
            resp_base <= next_nbits;
          end
        end
      end
    end
  end

  // Ref-domain sources are frozen while select is low
  always_comb begin
    if (addr_kind(own_addr[`DFR_A_HI:`DFR_A_LO]) == DFR_K_CTRL) begin
      resp = ctrl_mem[ctrl_idx(own_addr[`DFR_A_HI:`DFR_A_LO])];
    end else if (own_addr[`DFR_A_HI:`DFR_A_LO] == `DFR_ADDR_GSTAT) begin
      resp = snap;
    end else begin
      resp = 8'h00;
    end
  end

  always_comb begin
    pos_k = started ? nbits + 12'h001 : 12'h001;
    if (pos_k <= `DFR_BYTE_BITS) begin
      next_sdo = snap[3'(`DFR_BYTE_BITS - pos_k)]; // (R5) (R19)
    end else if (started && addr_done && pos_k > resp_base && pos_k <= resp_base + `DFR_BYTE_BITS) begin
      next_sdo = resp[3'(resp_base + `DFR_BYTE_BITS - pos_k)]; // (R16)
    end else begin
      next_sdo = rx_sr[7]; // (R20)
    end
  end

  always_ff @(posedge spi_clk_in) begin
    sdo_q <= next_sdo; // (R23)
  end

  // ---------------- Reference domain ----------------
  always_ff @(posedge ref_clk_in) begin
    link_clr <= ~nrst_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_prev <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      flt_s1 <= '0;
      flt_s2 <= '0;
    end else begin
      cs_s1 <= chip_select_n_in;
      cs_s2 <= cs_s1;
      cs_prev <= cs_s2;
      sck_s1 <= spi_clk_in;
      sck_s2 <= sck_s1;
      tgl_s1 <= frm_tgl;
      tgl_s2 <= tgl_s1;
      flt_s1 <= faults_in;
      flt_s2 <= flt_s1;
    end
  end

  assign cs_fall = cs_prev & ~cs_s2;
  assign cs_rise = ~cs_prev & cs_s2;

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      pol_seen <= 1'b0;
      tgl_seen <= 1'b0;
    end else begin
      if (cs_fall) begin
        pol_seen <= sck_s2; // (R14)
      end
      if (cs_rise) begin
        tgl_seen <= tgl_s2;
      end
    end
  end

  // Frame verdict at select release; a zero-clock frame is a flag read checked only for clock polarity
  always_comb begin
    clocked = tgl_s2 != tgl_seen;
    cnt_bad = clocked && (nbits[2:0] != 3'h0 || nbits < `DFR_MIN_BITS); // (R10)
    akind = addr_kind(own_addr[`DFR_A_HI:`DFR_A_LO]);
    // Address phase that leaves no data byte behind it means the token came too late
    addr_bad = clocked && !cnt_bad && (akind == DFR_K_UNUSED || lsb_err || !addr_done || nbits <= resp_base); // (R11) (R12) (R13)
    frame_bad = pol_seen | sck_s2 | cnt_bad | addr_bad; // (R14)
    apply = cs_rise && !frame_bad && clocked && own_addr[`DFR_A_KIND]; // (R22) (R24) (R25)
    wr_en = apply && akind == DFR_K_CTRL;
    clr_en = apply && own_addr[`DFR_A_HI:`DFR_A_LO] == `DFR_ADDR_GSTAT;
  end

  // Set wins over clear so a fault arriving during a clear is kept
  always_comb begin
    next_gstat = clr_en ? `DFR_GS_CLEARED : gstat;
    if (cs_rise && frame_bad) begin
      next_gstat[`DFR_GS_FERR] = 1'b1; // (R9)
    end
    next_gstat[`DFR_GS_LOAD] = next_gstat[`DFR_GS_LOAD] | flt_s2.open_load_fault | flt_s2.overcurrent_fault; // (R6)
    next_gstat[`DFR_GS_UV] = next_gstat[`DFR_GS_UV] | flt_s2.supply_undervoltage_flag; // (R2)
    next_gstat[`DFR_GS_OV] = next_gstat[`DFR_GS_OV] | flt_s2.supply_overvoltage_flag;
    next_gstat[`DFR_GS_TSD] = next_gstat[`DFR_GS_TSD] | flt_s2.thermal_shutdown_flag;
    next_gstat[`DFR_GS_TPW] = next_gstat[`DFR_GS_TPW] | flt_s2.thermal_warning_flag;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      gstat <= `DFR_GS_RESET; // (R8)
    end else begin
      gstat <= next_gstat;
    end
  end

  // Snapshot keeps the shifted byte steady while faults keep arriving
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      snap <= `DFR_GS_RESET;
    end else if (cs_fall) begin
      snap <= gstat; // (R5)
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < `DFR_CTRL_NUM; i++) begin
        ctrl_mem[i] <= 8'h00;
      end
    end else if (wr_en) begin
      ctrl_mem[ctrl_idx(own_addr[`DFR_A_HI:`DFR_A_LO])] <= data_byte; // (R25)
    end
  end

  // ---------------- Checks ----------------
  pre_edge_out_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R1)
    (!chip_select_n_in && !rose) |-> (serial_out == (global_fault_flag | serial_in)))
    else $error("pre-clock output is not flag OR input");

  fault_sets_gef_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R2)
    (|flt_s2) |=> global_fault_flag [*2])
    else $error("fault did not raise the fault flag");

  not_power_on_reset_flag_default_a: assert property (@(posedge ref_clk_in) // (R8)
    !nrst_in |=> (!gstat[`DFR_GS_NOT_POWER_ON_RESET_FLAG] && global_fault_flag))
    else $error("reset bit or fault flag wrong after reset");

  clean_gef_low_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R7)
    (gstat == `DFR_GS_CLEARED) |-> !global_fault_flag)
    else $error("fault flag high with clean status");

  ferr_next_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R9)
    (cs_rise && frame_bad) |=> gstat[`DFR_GS_FERR] ##1 gstat[`DFR_GS_FERR])
    else $error("frame error not latched");

  ferr_snap_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R9)
    (cs_fall && gstat[`DFR_GS_FERR]) |=> snap[`DFR_GS_FERR])
    else $error("frame error missing from next status byte");

  odd_count_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R10)
    (cs_rise && clocked && nbits[2:0] != 3'h0) |-> frame_bad)
    else $error("bad clock count accepted");

  pol_check_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R14)
    (cs_fall && sck_s2) |=> pol_seen)
    else $error("clock polarity error lost");

  pol_err_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R14)
    (cs_rise && pol_seen) |=> gstat[`DFR_GS_FERR])
    else $error("clock polarity error not reported");

  bad_no_apply_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R25)
    (cs_rise && frame_bad) |=> ($stable(ctrl_mem[0]) && $stable(ctrl_mem[1]) && !$past(clr_en)))
    else $error("write or clear on a bad frame");

  release_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // (R24)
    chip_select_n_in |-> !serial_oe_out)
    else $error("output still driven after select release");

  zero_clk_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in) cs_rise && !clocked);
  good_write_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in) wr_en);
  status_clear_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in) clr_en);
  frame_err_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in) cs_rise && frame_bad);

endmodule

// ==== testbench/dfr_ctl_model.sv ====
// Controller-side model that runs mode-1 frames on the serial link
`timescale 1ns/10ps
module dfr_ctl_model (
  output logic spi_clk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Negative count runs a clockless frame with the clock held high at both select edges
  task automatic frame(input logic [15:0] word, input int n, output logic [15:0] resp, output logic flag);
    resp = 16'h0000;
    spi_clk_out = (n < 0);
    mosi_out = 1'b0;
    #100;
    cs_n_out = 1'b0;
    #250;
    flag = miso_in;
    for (int i = 0; i < n; i++) begin
      spi_clk_out = 1'b1;
      mosi_out = word[15 - i];
      #62.5;
      spi_clk_out = 1'b0;
      resp = {resp[14:0], miso_in};
      #62.5;
    end
    #100;
    cs_n_out = 1'b1;
    // Idle data line toggles so a stale level is never mistaken for a driven one
    mosi_out = ~mosi_out;
    #100;
    spi_clk_out = 1'b0;
    #300;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the serial fault-reporting target
`timescale 1ns/10ps
`include "dfr_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import dfr_pkg::*;
  localparam logic [59:0] CA = `DFR_CTRL_ADDRS;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  dfr_fault_s faults_in = '0;
  logic spi_clk, cs_n, mosi, serial_out, serial_oe_out;
  logic [7:0] status_out;
  logic [95:0] ctrl_regs_out;
  logic [7:0] exp_ctrl [12] = '{default: 8'h00};
  logic [7:0] eb [5] = '{8'h82, 8'h81, 8'hff, 8'h83, 8'h00};
  int en [5] = '{16, 16, 16, 12, -1};
  integer seed = 7422;
  int bad_count = 0;
  int total_checks = 0;
  int idx;
  logic [4:0] a;
  logic [7:0] d;
  logic [15:0] r;
  logic fl;
  dfr_fault_s f;

  always #25 ref_clk_in = ~ref_clk_in;

  dfr_spi_target dfr_spi_target_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .spi_clk_in(spi_clk),
    .chip_select_n_in(cs_n), .serial_in(mosi), .faults_in(faults_in), .serial_out(serial_out),
    .serial_oe_out(serial_oe_out), .status_out(status_out), .ctrl_regs_out(ctrl_regs_out));
  dfr_ctl_model dfr_ctl_model_inst (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(serial_oe_out ? serial_out : ~serial_out));

  function automatic logic [7:0] exp_stat(input logic ferr, input dfr_fault_s x, input logic not_power_on_reset_flag);
    return {ferr, x.open_load_fault | x.overcurrent_fault, x.supply_undervoltage_flag,
      x.supply_overvoltage_flag, not_power_on_reset_flag, x.thermal_shutdown_flag, x.thermal_warning_flag, 1'b0};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    dfr_ctl_model_inst.frame(16'h0000, 0, r, fl);
    `CHK("flag_after_reset", 1'b1, fl)
    `CHK("status_after_reset", 8'h00, status_out)
    dfr_ctl_model_inst.frame(16'h9b00, 16, r, fl);
    `CHK("status_byte", 8'h00, r[15:8])
    `CHK("status_resp", 8'h00, r[7:0])
    `CHK("status_cleared", `DFR_GS_CLEARED, status_out)
    `CHK("oe_released", 1'b0, serial_oe_out)
    dfr_ctl_model_inst.frame(16'h0000, 0, r, fl);
    `CHK("flag_clean", 1'b0, fl)
    $display("test reset_and_clear done");
    for (int k = 0; k < 6; k++) begin
      idx = $unsigned($random(seed)) % 12;
      d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      a = CA[5*idx +: 5];
      dfr_ctl_model_inst.frame({1'b1, a, 2'b11, d}, 16, r, fl);
      `CHK("write_resp", exp_ctrl[idx], r[7:0])
      exp_ctrl[idx] = d;
      `CHK("ctrl_written", d, ctrl_regs_out[8*idx +: 8])
      dfr_ctl_model_inst.frame({1'b0, a, 2'b11, ~d}, 16, r, fl);
      `CHK("read_resp", d, r[7:0])
      `CHK("read_keeps", d, ctrl_regs_out[8*idx +: 8])
    end
    $display("test control_access done");
    for (int k = 0; k < 5; k++) begin
      dfr_ctl_model_inst.frame({eb[k], ~exp_ctrl[0]}, en[k], r, fl);
      `CHK("bad_not_applied", exp_ctrl[0], ctrl_regs_out[7:0])
      `CHK("err_latched", 1'b1, status_out[`DFR_GS_FERR])
      dfr_ctl_model_inst.frame(16'h9b00, 16, r, fl);
      `CHK("err_flag", 1'b1, fl)
      `CHK("err_next_frame", 8'h88, r[15:8])
      `CHK("err_cleared", `DFR_GS_CLEARED, status_out)
      dfr_ctl_model_inst.frame(16'h0300, 16, r, fl);
      `CHK("verify_after_err", exp_ctrl[0], r[7:0])
    end
    $display("test frame_errors done");
    for (int k = 0; k < 3; k++) begin
      @(negedge ref_clk_in);
      faults_in = 6'(1 << (2 * k)) | 6'($random(seed));
      f = faults_in;
      repeat (5) @(negedge ref_clk_in);
      `CHK("fault_status", exp_stat(1'b0, f, 1'b1), status_out)
      dfr_ctl_model_inst.frame(16'h0000, 0, r, fl);
      `CHK("fault_flag", 1'b1, fl)
      @(negedge ref_clk_in);
      faults_in = '0;
      repeat (5) @(negedge ref_clk_in);
      dfr_ctl_model_inst.frame(16'h9b00, 16, r, fl);
      `CHK("fault_byte", exp_stat(1'b0, f, 1'b1), r[15:8])
      `CHK("fault_cleared", `DFR_GS_CLEARED, status_out)
    end
    $display("test fault_reporting done");
    tally_and_finish();
  end
endmodule
